/* logic/ssd_pkg.sv */
// package of constants for the static seven-segment display host controller
// Function
// RL1: data is positive-true 4-bit binary, weights 1-2-4-8
// RL2: hex variant shows characters 0 through F
// RL3: code B variant shows 0-9, dash, E, H, L, P, blank
// RL4: both variants decode BCD 0-9 correctly
// RL5: decoder is a fixed 16-entry font table
// RL6: high digit strobe latches decoded data into digit
// RL7: multiple strobes write same character, data held stable
// RL8: latches transparent while both chip selects low
// RL9: rising chip select stores data at selected digit
// RL10: select code reversed: 00 is most significant digit
// RL11: on/off high blanks all segments
// RL12: host may pulse on/off for brightness duty cycle
// RL13: digit latch holds until rewritten, blanking keeps contents
package ssd_pkg;

  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned NS_PER_S    = 1_000_000_000;

  // device minimum times, in nanoseconds
  localparam int unsigned T_SA_NS     = 1000;
  localparam int unsigned T_DS_NS     = 500;
  localparam int unsigned T_DH_NS     = 200;
  localparam int unsigned T_IDS_NS    = 2000;
  localparam int unsigned T_CSA_NS    = 200;
  localparam int unsigned T_DSM_NS    = 100;
  localparam int unsigned T_DHM_NS    = 10;
  localparam int unsigned T_ICS_NS    = 2000;

  // least times round up, never below one cycle
  function automatic int unsigned min_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * (CLK_HZ / 1_000_000) + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned SA_CYC      = min_cyc(T_SA_NS);
  localparam int unsigned DS_CYC      = min_cyc(T_DS_NS);
  localparam int unsigned DH_CYC      = min_cyc(T_DH_NS);
  localparam int unsigned IDS_CYC     = min_cyc(T_IDS_NS);
  localparam int unsigned CSA_CYC     = min_cyc(T_CSA_NS);
  localparam int unsigned DSM_CYC     = min_cyc(T_DSM_NS);
  localparam int unsigned DHM_CYC     = min_cyc(T_DHM_NS);
  localparam int unsigned ICS_CYC     = min_cyc(T_ICS_NS);

  localparam int unsigned CNT_W       = 8;
  localparam int unsigned NUM_DIGITS  = 4;
  localparam int unsigned DATA_W      = 4;
  localparam int unsigned CODE_W      = 2;

  // select code for a digit index, index 0 is the least significant digit
  function automatic logic [CODE_W-1:0] digit_code(input logic [CODE_W-1:0] idx);
    return ~idx; // RL10
  endfunction

  typedef enum logic [2:0] {
    SSD_IDLE  = 3'b000,
    SSD_SETUP = 3'b001,
    SSD_ACT   = 3'b010,
    SSD_HOLD  = 3'b011,
    SSD_GAP   = 3'b100
  } ssd_state_t;

endpackage

/* logic/ssd_dim.sv */
// brightness pulse generator for the on/off pin
`timescale 1ns/10ps
module ssd_dim
  import ssd_pkg::*;
#(
  parameter int unsigned PERIOD = 256
)
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       blank_i,
  input  wire logic [7:0] duty_i,
  // pin
  output logic            display_off_o
);
  import ssd_pkg::*;

  if (PERIOD < 2 || PERIOD > 256)
  begin : g_bad_period
    $error("ssd_dim: PERIOD out of range");
  end

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       off_q;
  logic       off_d;

  always_comb
  begin
    cnt_d = (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
    // high blanks the display, so off for the part beyond the duty count
    off_d = blank_i | (cnt_q >= duty_i); // RL12 RL11
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 8'h00;
      off_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      off_q <= off_d;
    end
  end

  assign display_off_o = off_q;

endmodule

/* logic/ssd_host.sv */
// host controller writing digits to the static seven-segment decoder
`timescale 1ns/10ps
module ssd_host
  import ssd_pkg::*;
#(
  parameter bit          PROC_MODE = 1'b1,
  parameter int unsigned DIM_PERIOD = 256
)
(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // user write request
  input  wire logic                 wr_valid_i,
  output logic                      wr_ready_o,
  input  wire logic [3:0]           wr_digits_i,
  input  wire logic [3:0]           wr_value_i,
  // user brightness
  input  wire logic                 blank_i,
  input  wire logic [7:0]           duty_i,
  // device data pins
  output logic                      data_bit_ones_o,
  output logic                      data_bit_twos_o,
  output logic                      data_bit_fours_o,
  output logic                      data_bit_eights_o,
  // multiplexed variant strobes, lsd first
  output logic [3:0]                digit_strobe_o,
  // processor variant select and chip selects
  output logic                      digit_code_lsb_o,
  output logic                      digit_code_msb_o,
  output logic                      chip_sel_a_n_o,
  output logic                      chip_sel_b_n_o,
  // display blanking
  output logic                      display_off_o
);
  import ssd_pkg::*;

  localparam int unsigned SETUP_C = PROC_MODE ? DSM_CYC : DS_CYC;
  localparam int unsigned ACT_C   = PROC_MODE ? CSA_CYC : SA_CYC;
  localparam int unsigned HOLD_C  = PROC_MODE ? DHM_CYC : DH_CYC;
  localparam int unsigned GAP_C   = PROC_MODE ? ICS_CYC : IDS_CYC;

  // every phase lasts at least one cycle and must fit the down counter
  if (SETUP_C < 1 || ACT_C < 1 || HOLD_C < 1 || GAP_C < 1)
  begin : g_bad_zero
    $error("ssd_host: a timing count is zero");
  end
  if (SETUP_C > (1 << CNT_W) || ACT_C > (1 << CNT_W) ||
      HOLD_C > (1 << CNT_W) || GAP_C > (1 << CNT_W))
  begin : g_bad_wide
    $error("ssd_host: timing counts do not fit counter");
  end
  // the pin groups are fixed at four digits of four bits
  if (NUM_DIGITS != 4 || DATA_W != 4 || CODE_W != 2)
  begin : g_bad_shape
    $error("ssd_host: unsupported digit or data width");
  end
  if (DIM_PERIOD < 2 || DIM_PERIOD > 256)
  begin : g_bad_dim
    $error("ssd_host: DIM_PERIOD out of range");
  end

  ssd_state_t            st_q,  st_d;
  logic [CNT_W-1:0]      cnt_q, cnt_d;
  logic [DATA_W-1:0]     val_q, val_d;
  logic [NUM_DIGITS-1:0] dig_q, dig_d;
  logic [1:0]            idx_q, idx_d;
  logic [3:0]            strb_q, strb_d;
  logic                  cs_n_q, cs_n_d;
  logic [CODE_W-1:0]     code_q, code_d;

  // lowest pending digit, used to walk a multi-digit request in processor mode
  function automatic logic [1:0] first_one(input logic [3:0] m);
    if (m[0])      return 2'h0;
    else if (m[1]) return 2'h1;
    else if (m[2]) return 2'h2;
    else           return 2'h3;
  endfunction

  // the down counter loads n-1 so that a phase lasts exactly n cycles
  function automatic logic [CNT_W-1:0] cnt_load(input int unsigned n);
    return CNT_W'(n - 1);
  endfunction

  // a request made while busy is simply not taken
  assign wr_ready_o = (st_q == SSD_IDLE);

  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    val_d  = val_q;
    dig_d  = dig_q;
    idx_d  = idx_q;
    strb_d = strb_q;
    cs_n_d = cs_n_q;
    code_d = code_q;
    case (st_q)
      SSD_IDLE:
      begin
        if (wr_valid_i && wr_digits_i != 4'h0)
        begin
          val_d  = wr_value_i; // RL1
          dig_d  = wr_digits_i;
          idx_d  = first_one(wr_digits_i);
          code_d = digit_code(first_one(wr_digits_i)); // RL10
          cnt_d  = cnt_load(SETUP_C);
          st_d   = SSD_SETUP;
        end
      end
      SSD_SETUP:
      begin
        if (cnt_q == '0)
        begin
          cnt_d = cnt_load(ACT_C);
          st_d  = SSD_ACT;
          // both selects low opens the device's input latches
          if (PROC_MODE)
            cs_n_d = 1'b0; // RL8
          else
            strb_d = dig_q; // RL6 RL7
        end
        else
          cnt_d = cnt_q - 1'b1;
      end
      SSD_ACT:
      begin
        if (cnt_q == '0)
        begin
          // rising chip select commits the write; data stays put for hold
          cs_n_d = 1'b1; // RL9
          strb_d = 4'h0;
          cnt_d  = cnt_load(HOLD_C);
          st_d   = SSD_HOLD;
        end
        else
          cnt_d = cnt_q - 1'b1;
      end
      SSD_HOLD:
      begin
        if (cnt_q == '0)
        begin
          cnt_d = cnt_load(GAP_C);
          st_d  = SSD_GAP;
          if (PROC_MODE)
            dig_d = dig_q & ~(4'h1 << idx_q);
          else
            // one strobe pulse already wrote every masked digit
            dig_d = 4'h0;
        end
        else
          cnt_d = cnt_q - 1'b1;
      end
      SSD_GAP:
      begin
        if (cnt_q == '0)
        begin
          if (dig_q != 4'h0)
          begin
            idx_d  = first_one(dig_q);
            // next pending digit reuses the value still on the data pins
            code_d = digit_code(first_one(dig_q));
            cnt_d  = cnt_load(SETUP_C);
            st_d   = SSD_SETUP;
          end
          else
            st_d = SSD_IDLE;
        end
        else
          cnt_d = cnt_q - 1'b1;
      end
      default:
      begin
        st_d = SSD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q   <= SSD_IDLE;
      cnt_q  <= '0;
      val_q  <= '0;
      dig_q  <= '0;
      idx_q  <= '0;
      strb_q <= '0;
      cs_n_q <= 1'b1;
      code_q <= '0;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      val_q  <= val_d;
      dig_q  <= dig_d;
      idx_q  <= idx_d;
      strb_q <= strb_d;
      cs_n_q <= cs_n_d;
      code_q <= code_d;
    end
  end

  // both chip selects driven together so the active width is one pulse
  assign chip_sel_a_n_o    = cs_n_q;
  assign chip_sel_b_n_o    = cs_n_q;
  assign digit_strobe_o    = strb_q;
  assign digit_code_lsb_o  = code_q[0];
  assign digit_code_msb_o  = code_q[1];
  assign data_bit_ones_o   = val_q[0]; // RL1
  assign data_bit_twos_o   = val_q[1];
  assign data_bit_fours_o  = val_q[2];
  assign data_bit_eights_o = val_q[3];

  ssd_dim #(
    .PERIOD (DIM_PERIOD)
  ) u_dim (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .blank_i       (blank_i),
    .duty_i        (duty_i),
    .display_off_o (display_off_o)
  );

endmodule

/* tb/ssd_host_chk.sv */
// pin sequencing assertions for the host controller
`timescale 1ns/10ps
module ssd_host_chk
  import ssd_pkg::*;
#(
  parameter bit PROC_MODE = 1'b1
)
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wr_valid_i,
  input wire logic       wr_ready_o,
  input wire logic [3:0] wr_digits_i,
  input wire logic [3:0] wr_value_i,
  input wire logic       blank_i,
  input wire logic       data_bit_ones_o,
  input wire logic       data_bit_twos_o,
  input wire logic       data_bit_fours_o,
  input wire logic       data_bit_eights_o,
  input wire logic [3:0] digit_strobe_o,
  input wire logic       digit_code_lsb_o,
  input wire logic       digit_code_msb_o,
  input wire logic       chip_sel_a_n_o,
  input wire logic       chip_sel_b_n_o,
  input wire logic       display_off_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] dat;
  logic [1:0] code;
  logic       take;
  logic [4:0] gap_q;
  assign dat  = {data_bit_eights_o, data_bit_fours_o, data_bit_twos_o, data_bit_ones_o};
  assign code = {digit_code_msb_o, digit_code_lsb_o};
  assign take = wr_valid_i && wr_ready_o && (wr_digits_i != 4'h0);
  // saturating count of cycles with chip select released
  always_ff @(posedge clk_i)
  begin
    gap_q <= rst_i ? 5'h1f : (!chip_sel_a_n_o ? 5'h00 : gap_q + {4'h0, gap_q != 5'h1f});
  end
  property p_pair; chip_sel_a_n_o == chip_sel_b_n_o; endproperty
  a_pair: assert property (p_pair) else $error("chip selects differ");
  property p_stable; !chip_sel_a_n_o |-> $stable(dat) && $stable(code); endproperty
  a_stable: assert property (p_stable) else $error("data moved under select");
  property p_hold; $rose(chip_sel_a_n_o) |-> $stable(dat) && $stable(code); endproperty
  a_hold: assert property (p_hold) else $error("data moved at select rise");
  property p_gap; $fell(chip_sel_a_n_o) |-> gap_q >= ICS_CYC; endproperty
  a_gap: assert property (p_gap) else $error("select pulses too close");
  property p_walk;
    PROC_MODE && take |=> chip_sel_a_n_o ##1 !chip_sel_a_n_o[*2] ##1 chip_sel_a_n_o;
  endproperty
  a_walk: assert property (p_walk) else $error("select pulse misplaced");
  property p_data; take |=> dat == $past(wr_value_i) && !wr_ready_o; endproperty
  a_data: assert property (p_data) else $error("value not presented");
  property p_code; take && wr_digits_i[0] |=> code == 2'h3; endproperty
  a_code: assert property (p_code) else $error("lsd code wrong");
  property p_strobe; PROC_MODE |-> digit_strobe_o == 4'h0; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe in processor mode");
  property p_blank; blank_i |-> ##[1:2] display_off_o; endproperty
  a_blank: assert property (p_blank) else $error("blank not applied");
  property p_mux;
    !PROC_MODE && take |=> (digit_strobe_o == 4'h0)[*5]
      ##1 digit_strobe_o == $past(wr_digits_i, 6)
      ##9 digit_strobe_o == $past(wr_digits_i, 15) ##1 digit_strobe_o == 4'h0;
  endproperty
  a_mux: assert property (p_mux) else $error("strobe pulse misplaced");
  property p_mux_data; (digit_strobe_o != 4'h0) |-> $stable(dat); endproperty
  a_mux_data: assert property (p_mux_data) else $error("data moved under strobe");
  property p_mux_cs; !PROC_MODE |-> chip_sel_a_n_o && chip_sel_b_n_o; endproperty
  a_mux_cs: assert property (p_mux_cs) else $error("select in strobe mode");
endmodule
bind ssd_host ssd_host_chk #(.PROC_MODE(PROC_MODE)) ssd_host_chk_i (.*);

/* tb/ssd_dev_model.sv */
// behavioural model of the four-digit static decoder, hex font
`timescale 1ns/10ps
module ssd_dev_model
(
  input  wire logic [3:0]  dat_i,
  input  wire logic [1:0]  code_i,
  input  wire logic        cs_a_n_i,
  input  wire logic        cs_b_n_i,
  input  wire logic [3:0]  strobe_i,
  input  wire logic        off_i,
  output logic      [15:0] val_o,
  output logic      [27:0] seg_o
);
  logic [6:0] font [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
                            7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
  logic [3:0] in_d;
  logic [1:0] in_c;
  logic [3:0] lat [4];
  always @*
    if (!cs_a_n_i && !cs_b_n_i)
    begin
      in_d = dat_i;
      in_c = code_i;
    end
  always @(posedge cs_a_n_i or posedge cs_b_n_i)
    lat[~in_c] <= in_d;
  always @*
    for (int i = 0; i < 4; i++)
      if (strobe_i[i])
        lat[i] = dat_i;
  always @*
    for (int i = 0; i < 4; i++)
    begin
      val_o[4*i+:4] = lat[i];
      seg_o[7*i+:7] = off_i ? 7'h00 : font[lat[i]];
    end
endmodule

/* tb/ssd_host_bench.sv */
// self-checking bench: host controller driving the decoder model
`timescale 1ns/10ps
module ssd_host_bench;
  import ssd_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wr_valid_i = 1'b0, blank_i = 1'b0;
  logic [3:0] wr_digits_i = 4'h0, wr_value_i = 4'h0, strb, exp [4];
  logic [7:0] duty_i = 8'hff;
  logic d1, d2, d4, d8, cl, cm, ca, cb, off, rdy;
  logic rdy_m, off_m;
  logic [3:0] strb_m;
  wire [3:0] dat_m;
  logic [15:0] val_m;
  logic [27:0] seg_m;
  logic [15:0] val;
  logic [27:0] seg;
  int err_total = 0, compares = 0, seed = 32'hadb4407b, n, k;
  ssd_host #(.PROC_MODE(1'b1), .DIM_PERIOD(4)) ssd_host_i (.clk_i(clk_i), .rst_i(rst_i),
    .wr_valid_i(wr_valid_i), .wr_ready_o(rdy), .wr_digits_i(wr_digits_i),
    .wr_value_i(wr_value_i), .blank_i(blank_i), .duty_i(duty_i), .data_bit_ones_o(d1),
    .data_bit_twos_o(d2), .data_bit_fours_o(d4), .data_bit_eights_o(d8),
    .digit_strobe_o(strb), .digit_code_lsb_o(cl), .digit_code_msb_o(cm),
    .chip_sel_a_n_o(ca), .chip_sel_b_n_o(cb), .display_off_o(off));
  ssd_dev_model ssd_dev_model_i (.dat_i({d8, d4, d2, d1}), .code_i({cm, cl}), .cs_a_n_i(ca),
    .cs_b_n_i(cb), .strobe_i(strb), .off_i(off), .val_o(val), .seg_o(seg));
  // second controller in strobe mode, fed the same requests
  if (1'b1)
  begin : g_mux
    ssd_host #(.PROC_MODE(1'b0), .DIM_PERIOD(4)) ssd_host_i (.clk_i(clk_i), .rst_i(rst_i),
      .wr_valid_i(wr_valid_i), .wr_ready_o(rdy_m), .wr_digits_i(wr_digits_i),
      .wr_value_i(wr_value_i), .blank_i(blank_i), .duty_i(duty_i),
      .data_bit_ones_o(dat_m[0]), .data_bit_twos_o(dat_m[1]), .data_bit_fours_o(dat_m[2]),
      .data_bit_eights_o(dat_m[3]), .digit_strobe_o(strb_m), .digit_code_lsb_o(),
      .digit_code_msb_o(), .chip_sel_a_n_o(), .chip_sel_b_n_o(), .display_off_o(off_m));
    ssd_dev_model ssd_dev_model_i (.dat_i(dat_m), .code_i(2'h0), .cs_a_n_i(1'b1),
      .cs_b_n_i(1'b1), .strobe_i(strb_m), .off_i(off_m), .val_o(val_m), .seg_o(seg_m));
  end
  task automatic check(string what, logic [31:0] e, logic [31:0] s);
    compares++;
    if (e !== s)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wait_rdy;
    n = 0;
    while ((rdy & rdy_m) !== 1'b1 && n < 400)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check("ready", 32'h1, {31'h0, rdy & rdy_m});
  endtask
  task automatic put(logic [3:0] m, logic [3:0] v);
    wait_rdy();
    wr_digits_i = m;
    wr_value_i = v;
    wr_valid_i = 1'b1;
    @(posedge clk_i);
    #1;
    wr_valid_i = 1'b0;
    @(posedge clk_i);
    #1;
    wait_rdy();
    for (int i = 0; i < 4; i++)
      if (m[i])
        exp[i] = v;
    check("digits", {exp[3], exp[2], exp[1], exp[0]}, val);
    check("digits mux", {exp[3], exp[2], exp[1], exp[0]}, val_m);
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    forever #50 clk_i = ~clk_i;
  end
  initial
  begin
    #2000000;
    err_total++;
    results();
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    put(4'hf, 4'h8);
    $display("test fill done");
    for (int t = 0; t < 14; t++)
      put(4'($random(seed)), 4'($random(seed)));
    $display("test random done");
    blank_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    check("off", 32'h1, {31'h0, off});
    check("off mux", 32'h1, {31'h0, off_m});
    check("segments", 32'h0, {4'h0, seg});
    blank_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    check("kept", {exp[3], exp[2], exp[1], exp[0]}, val);
    check("kept mux", {exp[3], exp[2], exp[1], exp[0]}, val_m);
    $display("test blank done");
    for (int d = 0; d < 6; d += 2)
    begin
      duty_i = 8'(d);
      repeat (4) @(posedge clk_i);
      #1;
      k = 0;
      repeat (8)
      begin
        @(posedge clk_i);
        #1;
        k += (off === 1'b1);
      end
      check("dim", 8 - 2 * ((d < 4) ? d : 4), k);
    end
    $display("test dim done");
    results();
  end
endmodule
